// ===== pkg/tw_cfg.svh
// Register map, field positions, reset values and count limits of the timer.
`ifndef TW_CFG_SVH
`define TW_CFG_SVH
`define TW_OFS_CTRL_A 8'h00
`define TW_OFS_CTRL_B 8'h04
`define TW_OFS_COUNT 8'h08
`define TW_OFS_CMP_A 8'h0C
`define TW_OFS_CMP_B 8'h10
`define TW_OFS_CAPT 8'h14
`define TW_OFS_STAT 8'h18
`define TW_OFS_PORT 8'h1C
`define TW_COM_A_HI 7
`define TW_COM_A_LO 6
`define TW_COM_B_HI 5
`define TW_COM_B_LO 4
`define TW_FORCE_A 3
`define TW_FORCE_B 2
`define TW_WM_LOW_HI 1
`define TW_WM_LOW_LO 0
`define TW_WM_HIGH_HI 4
`define TW_WM_HIGH_LO 3
`define TW_ST_OVF 0
`define TW_ST_MATCH_A 1
`define TW_ST_MATCH_B 2
`define TW_ST_CAPT 3
`define TW_PT_DIR_A 0
`define TW_PT_DIR_B 1
`define TW_PT_DAT_A 2
`define TW_PT_DAT_B 3
`define TW_CTRL_RST 8'h00
`define TW_WORD_RST 16'h0000
`define TW_BOTTOM 16'h0000
`define TW_MAX 16'hFFFF
`define TW_TOP_8 16'h00FF
`define TW_TOP_9 16'h01FF
`define TW_TOP_10 16'h03FF
`define TW_ONE 16'h0001
`define TW_M_NORMAL 4'h0
`define TW_M_PC8 4'h1
`define TW_M_PC9 4'h2
`define TW_M_PC10 4'h3
`define TW_M_CTC_A 4'h4
`define TW_M_FP8 4'h5
`define TW_M_FP9 4'h6
`define TW_M_FP10 4'h7
`define TW_M_PFC_I 4'h8
`define TW_M_PFC_A 4'h9
`define TW_M_PC_I 4'hA
`define TW_M_PC_A 4'hB
`define TW_M_CTC_I 4'hC
`define TW_M_RSVD 4'hD
`define TW_M_FP_I 4'hE
`define TW_M_FP_A 4'hF
`endif

// ===== pkg/tw_pkg.sv
// Types shared by the timer top and its waveform output units.
package tw_pkg;
  typedef enum logic [1:0] {
    TW_CLS_NONPWM,
    TW_CLS_FAST,
    TW_CLS_DUAL
  } tw_class_t;

  typedef enum logic {
    TW_DIR_UP,
    TW_DIR_DOWN
  } tw_dir_t;

  typedef struct packed {
    logic [3:0] mode;
    tw_class_t cls;
    logic up;
    logic bottom;
  } tw_count_t;

  typedef struct packed {
    logic [1:0] com;
    logic match;
    logic cmp_is_top;
    logic force_hit;
  } tw_chan_t;
endpackage : tw_pkg

// ===== design/tw_wave_unit.sv
// Waveform output flip-flop of one compare channel.
`timescale 1ns/100ps
`include "tw_cfg.svh"
module tw_wave_unit #(
  parameter bit IS_A = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input tw_pkg::tw_count_t cnt,
  input tw_pkg::tw_chan_t ch,
  output logic wave_q,
  output logic connected
);
  import tw_pkg::*;

  logic wave_d;
  wire fast = (cnt.cls == TW_CLS_FAST);
  wire dual = (cnt.cls == TW_CLS_DUAL);
  wire nonpwm = (cnt.cls == TW_CLS_NONPWM);
  wire tog_fast = IS_A && fast && (cnt.mode == `TW_M_FP_A);
  wire tog_dual = IS_A && dual && ((cnt.mode == `TW_M_PFC_A) ||
                  (cnt.mode == `TW_M_FP_I));
  wire tog_ok = nonpwm || tog_fast || tog_dual;
  assign connected = ch.com[1] || (ch.com[0] && tog_ok);
  // A clear or set match that lands on TOP is dropped while the BOTTOM action stays.
  wire fast_hit = ch.match && !(ch.cmp_is_top && ch.com[1]);
  wire hit = nonpwm ? (ch.match || ch.force_hit) :
             fast ? fast_hit : ch.match;
  // A dual-slope match at TOP acts as the down-counting one and one at
  // BOTTOM as the up-counting one, so the extreme values hold a level.
  wire up_hit = (cnt.up || cnt.bottom) && !ch.cmp_is_top;

  always_comb begin
    wave_d = wave_q;
    if (ch.com == 2'h1) begin
      if (hit && tog_ok) begin
        wave_d = !wave_q;
      end
    end else if (ch.com[1]) begin
      if (nonpwm && hit) begin
        wave_d = ch.com[0];
      end else if (fast) begin
        if (hit) begin
          wave_d = ch.com[0];
        end else if (cnt.bottom) begin
          wave_d = !ch.com[0];
        end
      end else if (dual && hit) begin
        wave_d = up_hit ? ch.com[0] : !ch.com[0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end
endmodule : tw_wave_unit

// ===== design/tw_timer.sv
// Sixteen-bit timer with wave mode control and AHB-Lite register access.
`timescale 1ns/100ps
`include "tw_cfg.svh"
module tw_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic capture_pin,
  input wire logic [1:0] wave_pin_in,
  output logic [1:0] wave_pin_out,
  output logic [1:0] wave_pin_oe_n,
  output logic [1:0] wave_out,
  output logic overflow_flag
);
  import tw_pkg::*;

  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] cmp_buf_q [2];
  logic [15:0] cmp_act_q [2];
  logic [15:0] capt_q;
  logic [3:0] stat_q;
  logic [3:0] port_q;
  logic cap_prev_q;
  tw_dir_t dir_q;
  tw_dir_t dir_d;
  logic dph_q;
  logic dwr_q;
  logic [7:0] daddr_q;
  logic rd_done_q;
  logic [31:0] hrdata_q;

  // Bus decode. Reads take one wait state so that a read right after a
  // write to the same register returns the new value.
  wire aph = hsel && htrans[1] && hready;
  wire wr_cyc = dph_q && dwr_q;
  wire rd_wait = dph_q && !dwr_q && !rd_done_q;
  wire [7:0] wa = daddr_q;
  wire wr_ctrl_a = wr_cyc && (wa == `TW_OFS_CTRL_A);
  wire wr_ctrl_b = wr_cyc && (wa == `TW_OFS_CTRL_B);
  wire wr_count = wr_cyc && (wa == `TW_OFS_COUNT);
  wire wr_cmp_a = wr_cyc && (wa == `TW_OFS_CMP_A);
  wire wr_cmp_b = wr_cyc && (wa == `TW_OFS_CMP_B);
  wire wr_capt = wr_cyc && (wa == `TW_OFS_CAPT);
  wire wr_stat = wr_cyc && (wa == `TW_OFS_STAT);
  wire wr_port = wr_cyc && (wa == `TW_OFS_PORT);
  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Mode decode.
  wire [3:0] mode = {ctrl_b_q[`TW_WM_HIGH_HI:`TW_WM_HIGH_LO],
                     ctrl_a_q[`TW_WM_LOW_HI:`TW_WM_LOW_LO]};
  wire is_fast = (mode == `TW_M_FP8) || (mode == `TW_M_FP9) ||
                 (mode == `TW_M_FP10) || (mode == `TW_M_FP_I) ||
                 (mode == `TW_M_FP_A);
  wire is_pfc = (mode == `TW_M_PFC_I) || (mode == `TW_M_PFC_A);
  wire is_pc = (mode == `TW_M_PC8) || (mode == `TW_M_PC9) ||
               (mode == `TW_M_PC10) || (mode == `TW_M_PC_I) ||
               (mode == `TW_M_PC_A);
  wire is_dual = is_pc || is_pfc;
  wire is_nonpwm = !is_fast && !is_dual;
  wire top_capt = (mode == `TW_M_PFC_I) || (mode == `TW_M_PC_I) ||
                  (mode == `TW_M_CTC_I) || (mode == `TW_M_FP_I);
  wire top_cmp_a = (mode == `TW_M_CTC_A) || (mode == `TW_M_PFC_A) ||
                   (mode == `TW_M_PC_A) || (mode == `TW_M_FP_A);
  wire top_8 = (mode == `TW_M_PC8) || (mode == `TW_M_FP8);
  wire top_9 = (mode == `TW_M_PC9) || (mode == `TW_M_FP9);
  wire top_10 = (mode == `TW_M_PC10) || (mode == `TW_M_FP10);
  // The reserved mode falls back to a free-running 16-bit count.
  wire [15:0] top = top_capt ? capt_q :
                    top_cmp_a ? cmp_act_q[0] :
                    top_8 ? `TW_TOP_8 :
                    top_9 ? `TW_TOP_9 :
                    top_10 ? `TW_TOP_10 : `TW_MAX;
  tw_class_t cls;
  assign cls = is_fast ? TW_CLS_FAST :
               is_dual ? TW_CLS_DUAL : TW_CLS_NONPWM;

  // Counting sequence.
  wire at_top = (count_q == top);
  wire at_bottom = (count_q == `TW_BOTTOM);
  wire at_max = (count_q == `TW_MAX);
  wire going_up = (dir_q == TW_DIR_UP);
  wire turn_down = is_dual && going_up && at_top;
  wire turn_up = is_dual && !going_up && at_bottom;

  always_comb begin
    dir_d = dir_q;
    count_d = count_q + `TW_ONE;
    if (wr_count) begin
      count_d = hwdata[15:0];
    end else if (is_dual) begin
      if (turn_down) begin
        dir_d = TW_DIR_DOWN;
        count_d = count_q - `TW_ONE;
      end else if (turn_up) begin
        dir_d = TW_DIR_UP;
        count_d = count_q + `TW_ONE;
      end else if (!going_up) begin
        count_d = count_q - `TW_ONE;
      end
    end else begin
      dir_d = TW_DIR_UP;
      if (at_top) begin
        count_d = `TW_BOTTOM;
      end
    end
  end

  // Double-buffer update points and overflow flag points.
  wire upd_now = is_nonpwm ||
                 (is_pc && at_top && going_up) ||
                 (is_fast && at_top) ||
                 (is_pfc && turn_up);
  wire ovf_set = (is_nonpwm && at_max) ||
                 (is_dual && turn_up) ||
                 (is_fast && at_top);
  wire cap_en = !top_capt;
  wire cap_edge = cap_en && capture_pin && !cap_prev_q;

  // Force strobes: write-only pulses, honoured only outside PWM.
  wire [1:0] force_hit = {2{wr_ctrl_a && is_nonpwm}} &
                         {hwdata[`TW_FORCE_B], hwdata[`TW_FORCE_A]};
  wire [1:0] match;
  wire [1:0] connected;
  tw_count_t cnt;
  assign cnt = '{mode: mode, cls: cls, up: going_up,
                 bottom: at_bottom};
  wire [1:0] com [2];
  assign com[0] = ctrl_a_q[`TW_COM_A_HI:`TW_COM_A_LO];
  assign com[1] = ctrl_a_q[`TW_COM_B_HI:`TW_COM_B_LO];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      tw_chan_t ch;
      assign match[gi] = (count_q == cmp_act_q[gi]);
      assign ch = '{com: com[gi], match: match[gi],
                    cmp_is_top: (cmp_act_q[gi] == top),
                    force_hit: force_hit[gi]};
      tw_wave_unit #(
        .IS_A(gi == 0)
      ) u_wave (
        .hclk(hclk),
        .hresetn(hresetn),
        .cnt(cnt),
        .ch(ch),
        .wave_q(wave_out[gi]),
        .connected(connected[gi])
      );
      assign wave_pin_out[gi] = connected[gi] ? wave_out[gi] :
                                port_q[`TW_PT_DAT_A + gi];
      assign wave_pin_oe_n[gi] = !port_q[`TW_PT_DIR_A + gi];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cmp_buf_q[gi] <= `TW_WORD_RST;
        end else if (wr_cyc && (wa == `TW_OFS_CMP_A + 8'(gi * 4))) begin
          cmp_buf_q[gi] <= hwdata[15:0];
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cmp_act_q[gi] <= `TW_WORD_RST;
        end else if (upd_now) begin
          cmp_act_q[gi] <= cmp_buf_q[gi];
        end
      end
    end
  endgenerate

  // Status flags: hardware set wins over a write-one-to-clear. Forced
  // compares do not reach these flags.
  wire [3:0] stat_set = {cap_edge, match[1], match[0], ovf_set};
  wire [3:0] stat_clr = wr_stat ? hwdata[3:0] : 4'h0;
  assign overflow_flag = stat_q[`TW_ST_OVF];

  // Read mux; force bits always read back as zero.
  wire [7:0] ctrl_a_rd = ctrl_a_q &
                         ~(8'h1 << `TW_FORCE_A) &
                         ~(8'h1 << `TW_FORCE_B);
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux =
    (daddr_q == `TW_OFS_CTRL_A) ? {24'h0, ctrl_a_rd} :
    (daddr_q == `TW_OFS_CTRL_B) ? {24'h0, ctrl_b_q} :
    (daddr_q == `TW_OFS_COUNT) ? {16'h0, count_q} :
    (daddr_q == `TW_OFS_CMP_A) ? {16'h0, cmp_buf_q[0]} :
    (daddr_q == `TW_OFS_CMP_B) ? {16'h0, cmp_buf_q[1]} :
    (daddr_q == `TW_OFS_CAPT) ? {16'h0, capt_q} :
    (daddr_q == `TW_OFS_STAT) ? {28'h0, stat_q} :
    (daddr_q == `TW_OFS_PORT) ? {28'h0, port_q} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q <= 1'b0;
      dwr_q <= 1'b0;
      daddr_q <= 8'h00;
      rd_done_q <= 1'b0;
    end else if (!rd_wait) begin
      dph_q <= aph;
      dwr_q <= hwrite;
      daddr_q <= ra;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0;
    end else if (rd_wait) begin
      hrdata_q <= rd_mux;
    end
  end

  // Force bits are not kept, so later reads and modes never see them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a_q <= `TW_CTRL_RST;
    end else if (wr_ctrl_a) begin
      ctrl_a_q <= hwdata[7:0] & ctrl_a_rd_mask();
    end
  end

  function automatic logic [7:0] ctrl_a_rd_mask();
    ctrl_a_rd_mask = ~(8'h1 << `TW_FORCE_A) & ~(8'h1 << `TW_FORCE_B);
  endfunction : ctrl_a_rd_mask

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_b_q <= `TW_CTRL_RST;
    end else if (wr_ctrl_b) begin
      ctrl_b_q <= hwdata[7:0];
    end
  end

  // A counter write overrides counting in that cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= `TW_WORD_RST;
      dir_q <= TW_DIR_UP;
    end else begin
      count_q <= count_d;
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capt_q <= `TW_WORD_RST;
    end else if (wr_capt) begin
      capt_q <= hwdata[15:0];
    end else if (cap_edge) begin
      capt_q <= count_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_prev_q <= 1'b0;
    end else begin
      cap_prev_q <= capture_pin;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
    end
  end

  // Port data bits drive the pins whenever the compare field lets go.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_q <= 4'h0;
    end else if (wr_port) begin
      port_q <= hwdata[3:0];
    end
  end

  wire unused_ok = &{1'b0, hsize, wave_pin_in, is_pfc & 1'b0};
endmodule : tw_timer

// ===== dv/tw_pad_model.sv
// Pad model of the two waveform pins.
`timescale 1ns/100ps
module tw_pad_model (
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n,
  output logic [1:0] pad
);
  // A released pad floats up to its pull-up level, never to a stale value.
  assign pad[0] = pin_oe_n[0] ? 1'b1 : pin_out[0];
  assign pad[1] = pin_oe_n[1] ? 1'b1 : pin_out[1];
endmodule : tw_pad_model

// ===== dv/tw_timer_assertions.sv
// Checker of the timer's pin, force and readback behaviour.
`timescale 1ns/100ps
`include "tw_cfg.svh"
module tw_timer_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic [1:0] wave_pin_out,
  input wire logic [1:0] wave_pin_oe_n,
  input wire logic [1:0] wave_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_q, rd_q;
  logic [7:0] adr_q, ca_q, cb_q, pt_q;
  wire take = hsel & htrans[1] & hready;
  wire land = wr_q & hready;
  wire ld_a = land & (adr_q == `TW_OFS_CTRL_A);
  wire [3:0] md = {cb_q[4:3], ca_q[1:0]};
  wire npwm = md == 4'h0 | md == 4'h4 | md == 4'hC | md == 4'hD;
  // Only strobes that leave the field and mode unchanged are judged,
  // since the field in force at that moment is not pinned down otherwise.
  wire same = hwdata[1:0] == ca_q[1:0] & npwm;
  wire frc_a = ld_a & same & hwdata[3] & (hwdata[7:6] == ca_q[7:6]);
  wire frc_b = ld_a & same & hwdata[2] & (hwdata[5:4] == ca_q[5:4]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 8'h00;
      ca_q <= 8'h00;
      cb_q <= 8'h00;
      pt_q <= 8'h00;
    end else begin
      if (hready) begin
        wr_q <= take & hwrite;
        rd_q <= take & !hwrite;
        adr_q <= haddr[7:0];
      end
      if (ld_a) ca_q <= hwdata[7:0];
      if (land & adr_q == `TW_OFS_CTRL_B) cb_q <= hwdata[7:0];
      if (land & adr_q == `TW_OFS_PORT) pt_q <= hwdata[7:0];
    end
  end
  property p_oe_dir;
    wave_pin_oe_n == ~pt_q[1:0];
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin enable off");
  property p_claim_a;
    npwm && ca_q[7:6] != 2'b00 |-> wave_pin_out[0] == wave_out[0];
  endproperty
  a_claim_a: assert property (p_claim_a) else $error("pin A unclaimed");
  property p_claim_b;
    npwm && ca_q[5:4] != 2'b00 |-> wave_pin_out[1] == wave_out[1];
  endproperty
  a_claim_b: assert property (p_claim_b) else $error("pin B unclaimed");
  property p_free;
    ca_q[7:4] == 4'h0 |-> wave_pin_out == pt_q[3:2];
  endproperty
  a_free: assert property (p_free) else $error("port data lost");
  property p_force_a;
    frc_a && hwdata[7] |=> wave_out[0] == $past(hwdata[6]);
  endproperty
  a_force_a: assert property (p_force_a) else $error("force A level");
  property p_force_b;
    frc_b && hwdata[5:4] == 2'b01 |=> wave_out[1] != $past(wave_out[1]);
  endproperty
  a_force_b: assert property (p_force_b) else $error("force B toggle");
  property p_rd_ctrl;
    rd_q && hreadyout && adr_q == `TW_OFS_CTRL_A |-> hrdata[3:2] == 2'b00;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("force bits read");
  property p_reset;
    $rose(hresetn) |-> wave_pin_oe_n == 2'b11 && wave_out == 2'b00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
endmodule : tw_timer_checker
bind tw_timer tw_timer_checker u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .wave_pin_out,
  .wave_pin_oe_n, .wave_out);

// ===== dv/tb_top.sv
// Self-checking bench of the timer's wave mode control.
`timescale 1ns/100ps
`include "tw_cfg.svh"
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ovf, e, cap;
  logic [31:0] haddr, hwdata, hrdata, r, rv;
  logic [1:0] htrans, pin_out, oe_n, wave, pad;
  logic [1:0] codes [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h3};
  logic [15:0] cvs [8] = '{16'h40, 16'h40, 16'hFF, 16'hFF, 0, 16'h40, 0, 16'hFF};
  logic [3:0] cm [5] = '{4'hF, 4'h7, 4'h9, 4'hB, 4'h5};
  bit cl [5] = '{1, 0, 1, 0, 0};
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'h13E7;
  int hi;
  tw_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_pin(cap),
    .wave_pin_in(pad), .wave_pin_out(pin_out), .wave_pin_oe_n(oe_n),
    .wave_out(wave), .overflow_flag(ovf));
  tw_pad_model u_pad (.pin_out(pin_out), .pin_oe_n(oe_n), .pad(pad));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // The request starts just after a rising edge and stands until ready is
  // seen high at a rising edge; read data is taken at the closing edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    r = hrdata;
  endtask : bus
  function automatic int exp_hi(int per, logic [15:0] cv, logic [1:0] m);
    int h;
    h = per == 510 ? 2 * cv : (cv == `TW_TOP_8 ? 256 : cv);
    return m[0] ? per - h : h;
  endfunction : exp_hi
  task automatic duty(input logic [3:0] md, input logic [15:0] cv,
      input logic [1:0] m);
    int per;
    per = md == `TW_M_PC8 ? 510 : 256;
    bus(1, `TW_OFS_CTRL_A, 0);
    bus(1, `TW_OFS_CMP_A, {16'h0, cv});
    bus(1, `TW_OFS_CTRL_B, {27'h0, md[3:2], 3'h0});
    bus(1, `TW_OFS_CTRL_A, {24'h0, m, 4'h0, md[1:0]});
    bus(1, `TW_OFS_COUNT, 0);
    repeat (600) @(posedge hclk);
    hi = 0;
    repeat (per) begin
      @(negedge hclk);
      hi += pin_out[0];
    end
    chk("duty", hi, exp_hi(per, cv, m));
  endtask : duty
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  initial begin
    repeat (30000) @(posedge hclk);
    n_errors++;
    close_out();
  end
  initial begin : main
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 0;
    hwrite = 1'b0;
    hwdata = 0;
    cap = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    chk("oe_n", oe_n, 2'h3);
    bus(0, `TW_OFS_CTRL_A, 0);
    chk("ctrl_a", r, 0);
    bus(1, `TW_OFS_PORT, 32'h3);
    @(negedge hclk);
    chk("oe_n", oe_n, 2'h0);
    bus(1, `TW_OFS_STAT, 32'hF);
    e = 1'b0;
    foreach (codes[i]) begin
      bus(1, `TW_OFS_CTRL_A, {24'h0, codes[i], codes[i], 4'h0});
      bus(1, `TW_OFS_CTRL_A, {24'h0, codes[i], codes[i], 4'hC});
      e = codes[i] == 2'h1 ? !e : codes[i][0];
      @(negedge hclk);
      chk("force", wave, {e, e});
      chk("pin", pin_out, {e, e});
    end
    bus(0, `TW_OFS_STAT, 0);
    chk("flags", r, 0);
    repeat (8) begin
      rv = $random(seed);
      if (rv[1:0] != 2'h0) rv[3:2] = 2'h0;
      bus(1, `TW_OFS_CTRL_A, rv);
      bus(0, `TW_OFS_CTRL_A, 0);
      chk("ctrl_a", r, {24'h0, rv[7:4], 2'h0, rv[1:0]});
    end
    bus(1, 8'h40, 32'hFF);
    bus(0, 8'h40, 0);
    chk("unmapped", r, 0);
    bus(1, `TW_OFS_CTRL_A, 0);
    bus(1, `TW_OFS_STAT, 32'hF);
    bus(1, `TW_OFS_COUNT, 32'hFFF0);
    repeat (30) @(posedge hclk);
    chk("ovf", ovf, 1'b1);
    // Capture stays off while the capture register sets TOP.
    bus(1, `TW_OFS_CTRL_B, 32'h18);
    bus(1, `TW_OFS_STAT, 32'hF);
    cap <= 1'b1;
    @(posedge hclk);
    cap <= 1'b0;
    bus(0, `TW_OFS_STAT, 0);
    chk("capt_off", r[`TW_ST_CAPT], 1'b0);
    bus(1, `TW_OFS_CTRL_B, 0);
    cap <= 1'b1;
    @(posedge hclk);
    cap <= 1'b0;
    bus(0, `TW_OFS_STAT, 0);
    chk("capt_on", r[`TW_ST_CAPT], 1'b1);
    foreach (cvs[i]) begin
      rv = $random(seed);
      duty(i < 5 ? `TW_M_FP8 : `TW_M_PC8,
        cvs[i] == 0 ? {8'h0, rv[7:1], 1'b1} : cvs[i], i[0] ? 2'h3 : 2'h2);
    end
    bus(1, `TW_OFS_CTRL_A, 0);
    bus(1, `TW_OFS_CTRL_B, 0);
    bus(1, `TW_OFS_CMP_A, 32'h10);
    bus(1, `TW_OFS_PORT, 32'hF);
    foreach (cm[i]) begin
      bus(1, `TW_OFS_CTRL_B, {27'h0, cm[i][3:2], 3'h0});
      bus(1, `TW_OFS_CTRL_A, {24'h0, 4'h5, 2'h0, cm[i][1:0]});
      repeat (40) begin
        @(negedge hclk);
        chk("pin", pin_out, cl[i] ? {1'b1, wave[0]} : 2'h3);
      end
    end
    close_out();
  end
endmodule : tb_top
